// file: include/pafs_pkg.sv
// package for the port alternate function select block
package pafs_pkg;
    localparam int PORT_W = 8;
    // register indices on the plain register port
    localparam logic [3:0] REG_EN_A = 4'h0;
    localparam logic [3:0] REG_EN_B = 4'h1;
    localparam logic [3:0] REG_EN_C = 4'h2;
    localparam logic [3:0] REG_EN_D = 4'h3;
    localparam logic [3:0] REG_SEL_B1 = 4'h4;
    localparam logic [3:0] REG_SEL_C1 = 4'h5;
    localparam logic [3:0] REG_SEL_B2 = 4'h6;
    localparam logic [3:0] REG_SEL_C2 = 4'h7;
    localparam logic [3:0] REG_PKG = 4'h8;
    localparam logic [3:0] REG_STAT_C = 4'h9;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // package select codes
    localparam logic [1:0] PKG_MID = 2'h1;
    localparam logic [1:0] PKG_LARGE = 2'h2;
    // pin positions
    localparam int PIN_ANA_POS = 0;
    localparam int PIN_ANA_NEG = 1;
    localparam int PIN_ANA_SIX = 2;
    localparam int PIN_CMP_OUT = 3;
    localparam int PIN_B_VREF = 5;
    localparam int PIN_TMR0 = 0;
    localparam int PIN_TMR1 = 6;
    localparam int PIN_RST = 0;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pafs_bus_t;

    typedef struct packed {
        logic comparator_pos_input;
        logic comparator_neg_input;
        logic analog_in_six;
        logic vref_from_c;
        logic vref_from_b;
        logic comparator_output_pin;
    } pafs_analog_t;
endpackage : pafs_pkg

// file: verilog/pafs_top.sv
// port alternate function select: enables, set registers, pin routing
//
// Behaviour
// - port C pins 0,1 analog when select set
// - port C pin 2 analog or reference when set
// - reference on B5 large, C2 mid package
// - ports B, C use first set register only
// - port D pin 0 enable gives external reset
// - port A enable connects its single function
// - timer pins direction from timer configuration
`timescale 1ns/100ps
module pafs_top
    import pafs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire pafs_bus_t bus,
    output logic [7:0] rdata,
    // timer configuration (same clock)
    input wire logic tmr0_out_mode,
    input wire logic tmr1_out_mode,
    // port A routing
    output logic [PORT_W-1:0] a_alt_q,
    output logic tmr0_in_sel_q,
    output logic tmr0_outc_sel_q,
    output logic tmr1_in_sel_q,
    output logic tmr1_outc_sel_q,
    // port B, C, D routing
    output logic [PORT_W-1:0] b_alt_q,
    output logic [PORT_W-1:0] c_alt_q,
    output pafs_analog_t analog_q,
    output logic ext_reset_sel_q
);

////////////////////////////////////////////////////////////////////////////
// registers
logic [7:0] en_a_q, en_b_q, en_c_q, en_d_q;
logic [7:0] sel_b1_q, sel_c1_q, sel_b2_q, sel_c2_q;
logic [1:0] pkg_q;
logic [7:0] rdata_d;
logic [PORT_W-1:0] c_alt_d;
pafs_analog_t analog_d;

wire wr_en_a = bus.wr && bus.addr == REG_EN_A;
wire wr_en_b = bus.wr && bus.addr == REG_EN_B;
wire wr_en_c = bus.wr && bus.addr == REG_EN_C;
wire wr_en_d = bus.wr && bus.addr == REG_EN_D;
wire wr_sb1 = bus.wr && bus.addr == REG_SEL_B1;
wire wr_sc1 = bus.wr && bus.addr == REG_SEL_C1;
wire wr_sb2 = bus.wr && bus.addr == REG_SEL_B2;
wire wr_sc2 = bus.wr && bus.addr == REG_SEL_C2;
wire wr_pkg = bus.wr && bus.addr == REG_PKG;

always_ff @(posedge ref_clk) begin
    if (srst) begin
        en_a_q <= RST_BYTE;
        en_b_q <= RST_BYTE;
        en_c_q <= RST_BYTE;
        en_d_q <= RST_BYTE;
        sel_b1_q <= RST_BYTE;
        sel_c1_q <= RST_BYTE;
        sel_b2_q <= RST_BYTE;
        sel_c2_q <= RST_BYTE;
        pkg_q <= PKG_MID;
    end else begin
        if (wr_en_a) en_a_q <= bus.wdata;
        if (wr_en_b) en_b_q <= bus.wdata;
        if (wr_en_c) en_c_q <= bus.wdata;
        if (wr_en_d) en_d_q <= bus.wdata;
        if (wr_sb1) sel_b1_q <= bus.wdata;
        if (wr_sc1) sel_c1_q <= bus.wdata;
        // second set register is storage only for ports B and C
        if (wr_sb2) sel_b2_q <= bus.wdata;
        if (wr_sc2) sel_c2_q <= bus.wdata;
        if (wr_pkg) pkg_q <= bus.wdata[1:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// routing
// enable gate
wire [7:0] c_live = en_c_q & sel_c1_q;
wire is_large = pkg_q == PKG_LARGE;
wire is_mid = pkg_q == PKG_MID;

always_comb begin
    analog_d.comparator_pos_input = c_live[PIN_ANA_POS];
    analog_d.comparator_neg_input = c_live[PIN_ANA_NEG];
    analog_d.analog_in_six = c_live[PIN_ANA_SIX];
    analog_d.vref_from_c = c_live[PIN_ANA_SIX] && is_mid;
    analog_d.vref_from_b = en_b_q[PIN_B_VREF] && sel_b1_q[PIN_B_VREF]
        && is_large;
    // comparator output when select is zero
    analog_d.comparator_output_pin = en_c_q[PIN_CMP_OUT]
        && !sel_c1_q[PIN_CMP_OUT];
    c_alt_d = RST_BYTE;
    c_alt_d[PIN_ANA_POS] = c_live[PIN_ANA_POS];
    c_alt_d[PIN_ANA_NEG] = c_live[PIN_ANA_NEG];
    c_alt_d[PIN_ANA_SIX] = c_live[PIN_ANA_SIX];
    c_alt_d[PIN_CMP_OUT] = analog_d.comparator_output_pin;
end

always_ff @(posedge ref_clk) begin
    if (srst) begin
        a_alt_q <= RST_BYTE;
        b_alt_q <= RST_BYTE;
        c_alt_q <= RST_BYTE;
        analog_q <= '0;
        ext_reset_sel_q <= 1'b0;
        tmr0_in_sel_q <= 1'b0;
        tmr0_outc_sel_q <= 1'b0;
        tmr1_in_sel_q <= 1'b0;
        tmr1_outc_sel_q <= 1'b0;
        rdata <= RST_BYTE;
    end else begin
        a_alt_q <= en_a_q;
        b_alt_q <= en_b_q & sel_b1_q;
        c_alt_q <= c_alt_d;
        analog_q <= analog_d;
        ext_reset_sel_q <= en_d_q[PIN_RST];
        tmr0_in_sel_q <= en_a_q[PIN_TMR0] && !tmr0_out_mode;
        tmr0_outc_sel_q <= en_a_q[PIN_TMR0] && tmr0_out_mode;
        tmr1_in_sel_q <= en_a_q[PIN_TMR1] && !tmr1_out_mode;
        tmr1_outc_sel_q <= en_a_q[PIN_TMR1] && tmr1_out_mode;
        rdata <= rdata_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// read mux
always_comb begin
    rdata_d = RST_BYTE;
    if (bus.rd) begin
        case (bus.addr)
            REG_EN_A: rdata_d = en_a_q;
            REG_EN_B: rdata_d = en_b_q;
            REG_EN_C: rdata_d = en_c_q;
            REG_EN_D: rdata_d = en_d_q;
            REG_SEL_B1: rdata_d = sel_b1_q;
            REG_SEL_C1: rdata_d = sel_c1_q;
            REG_SEL_B2: rdata_d = sel_b2_q;
            REG_SEL_C2: rdata_d = sel_c2_q;
            REG_PKG: rdata_d = {6'h00, pkg_q};
            REG_STAT_C: rdata_d = c_alt_q;
            default: rdata_d = RST_BYTE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// checks
AST_C_ANALOG: assert property (@(posedge ref_clk) disable iff (srst)
    analog_q.comparator_pos_input
        == $past(en_c_q[PIN_ANA_POS] && sel_c1_q[PIN_ANA_POS]))
    else $error("pos input routing wrong");
AST_C_SIX: assert property (@(posedge ref_clk) disable iff (srst)
    analog_q.analog_in_six
        |-> $past(en_c_q[PIN_ANA_SIX] && sel_c1_q[PIN_ANA_SIX]))
    else $error("pin six routing wrong");
AST_VREF: assert property (@(posedge ref_clk) disable iff (srst)
    !(analog_q.vref_from_b && analog_q.vref_from_c))
    else $error("two reference pins");
AST_SEL2: assert property (@(posedge ref_clk) disable iff (srst)
    b_alt_q == $past(en_b_q & sel_b1_q))
    else $error("port B ignores first set");
AST_EN: assert property (@(posedge ref_clk) disable iff (srst)
    ($past(en_c_q) == RST_BYTE && $past(srst) == 1'b0)
        |-> c_alt_q == RST_BYTE)
    else $error("routed without enable");
AST_RST: assert property (@(posedge ref_clk) disable iff (srst)
    ext_reset_sel_q == $past(en_d_q[PIN_RST]))
    else $error("reset pin routing wrong");
AST_A: assert property (@(posedge ref_clk) disable iff (srst)
    a_alt_q == $past(en_a_q))
    else $error("port A routing wrong");
AST_TMR: assert property (@(posedge ref_clk) disable iff (srst)
    !(tmr0_in_sel_q && tmr0_outc_sel_q))
    else $error("timer pin both ways");
AST_RSV: assert property (@(posedge ref_clk) disable iff (srst)
    c_alt_q[PORT_W-1:PIN_CMP_OUT+1] == '0)
    else $error("reserved pin routed");
AST_C_NEG: assert property (@(posedge ref_clk) disable iff (srst)
    analog_q.comparator_neg_input
        == $past(en_c_q[PIN_ANA_NEG] && sel_c1_q[PIN_ANA_NEG]))
    else $error("neg input routing wrong");
AST_VREF_C: assert property (@(posedge ref_clk) disable iff (srst)
    analog_q.vref_from_c == $past(en_c_q[PIN_ANA_SIX]
        && sel_c1_q[PIN_ANA_SIX] && pkg_q == PKG_MID))
    else $error("reference on port C wrong");
AST_VREF_B: assert property (@(posedge ref_clk) disable iff (srst)
    analog_q.vref_from_b == $past(en_b_q[PIN_B_VREF]
        && sel_b1_q[PIN_B_VREF] && pkg_q == PKG_LARGE))
    else $error("reference on port B wrong");
AST_CMP_OUT: assert property (@(posedge ref_clk) disable iff (srst)
    c_alt_q[PIN_CMP_OUT] == $past(en_c_q[PIN_CMP_OUT]
        && !sel_c1_q[PIN_CMP_OUT]))
    else $error("comparator output routing wrong");
AST_TMR1: assert property (@(posedge ref_clk) disable iff (srst)
    !(tmr1_in_sel_q && tmr1_outc_sel_q))
    else $error("timer one pin both ways");
AST_TMR_IN0: assert property (@(posedge ref_clk) disable iff (srst)
    tmr0_in_sel_q == $past(en_a_q[PIN_TMR0] && !tmr0_out_mode))
    else $error("timer zero input routing wrong");
AST_TMR_OUT0: assert property (@(posedge ref_clk) disable iff (srst)
    tmr0_outc_sel_q == $past(en_a_q[PIN_TMR0] && tmr0_out_mode))
    else $error("timer zero output routing wrong");
AST_TMR_OUT1: assert property (@(posedge ref_clk) disable iff (srst)
    tmr1_outc_sel_q == $past(en_a_q[PIN_TMR1] && tmr1_out_mode))
    else $error("timer one output routing wrong");
AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(bus.rd) |-> rdata == RST_BYTE)
    else $error("read data outside read cycle");
COV_ANA: cover property (@(posedge ref_clk) analog_q.comparator_pos_input);
COV_VREF: cover property (@(posedge ref_clk) analog_q.vref_from_b);
COV_TMR: cover property (@(posedge ref_clk) tmr1_outc_sel_q);
COV_EXT: cover property (@(posedge ref_clk) ext_reset_sel_q);
COV_CMP: cover property (@(posedge ref_clk) analog_q.comparator_output_pin);
endmodule : pafs_top

// file: verification/pafs_timer_model.sv
// timer configuration model that sets the timer pin direction
`timescale 1ns/100ps
module pafs_timer_model (
    // mode request from bench
    input wire logic [1:0] mode_req,
    // timer configuration
    output logic tmr0_out_mode,
    output logic tmr1_out_mode
);
    assign tmr0_out_mode = mode_req[0];
    assign tmr1_out_mode = mode_req[1];
endmodule : pafs_timer_model

// file: verification/pafs_top_bench.sv
// self-checking bench for the port alternate function select block
`timescale 1ns/100ps
module pafs_top_bench;
    import pafs_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    pafs_bus_t bus = '0;
    logic [1:0] mode_req = 2'h0;
    logic [7:0] rdata, a_q, b_q, c_q, r[10];
    logic t0i, t0o, t1i, t1o, xrst, m0, m1;
    pafs_analog_t an;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    pafs_top i_dut (.ref_clk(ref_clk), .srst(srst), .bus(bus),
        .rdata(rdata), .tmr0_out_mode(m0), .tmr1_out_mode(m1),
        .a_alt_q(a_q), .tmr0_in_sel_q(t0i), .tmr0_outc_sel_q(t0o),
        .tmr1_in_sel_q(t1i), .tmr1_outc_sel_q(t1o), .b_alt_q(b_q),
        .c_alt_q(c_q), .analog_q(an), .ext_reset_sel_q(xrst));
    pafs_timer_model i_tmr (.mode_req(mode_req), .tmr0_out_mode(m0),
        .tmr1_out_mode(m1));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [7:0] e,
        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // pins 4-7 reserved, pin 3 routed when select is 0
    function automatic logic [7:0] cexp();
        return (r[2] & r[5] & 8'h07) | (r[2] & ~r[5] & 8'h08);
    endfunction : cexp
    function automatic logic [7:0] rexp(input logic [3:0] a);
        return a == REG_STAT_C ? cexp() : (a < 4'h9 ? r[a] : 8'h00);
    endfunction : rexp
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        if (a < 4'h9) r[a] = d;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 chk("rdata", rexp(a), rdata);
    endtask : rd
    task automatic check_all();
        logic [7:0] ec, eb;
        logic md, lg;
        repeat (3) @(posedge ref_clk);
        #1;
        ec = cexp();
        eb = r[1] & r[4];
        md = r[8][1:0] == PKG_MID;
        lg = r[8][1:0] == PKG_LARGE;
        chk("a_alt", r[0], a_q);
        chk("b_alt", eb, b_q);
        chk("c_alt", ec, c_q);
        chk("analog", {2'h0, ec[0], ec[1], ec[2], ec[2] & md, eb[5] & lg,
            ec[3]}, {2'h0, an});
        chk("timer", {4'h0, r[0][0] & ~mode_req[0], r[0][0] & mode_req[0],
            r[0][6] & ~mode_req[1], r[0][6] & mode_req[1]},
            {4'h0, t0i, t0o, t1i, t1o});
        chk("ext_reset", {7'h0, r[3][0]}, {7'h0, xrst});
    endtask : check_all
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] a;
        logic [7:0] d;
        void'($urandom(24631));
        foreach (r[i]) r[i] = 8'h00;
        r[8] = {6'h0, PKG_MID};
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        check_all();
        for (int i = 0; i < 16; i++) rd(4'(i));
        for (int n = 0; n < 80; n++) begin
            a = 4'($urandom_range(0, 15));
            d = 8'($urandom);
            if (a == REG_PKG) d = {6'h0, PKG_MID + 2'(n % 2)};
            wr(a, d);
            mode_req <= 2'($urandom);
            check_all();
            rd(a);
        end
        // second reset in mid-run brings every register back
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (r[i]) r[i] = 8'h00;
        r[8] = {6'h0, PKG_MID};
        check_all();
        rd(REG_PKG);
        rd(REG_STAT_C);
        final_report();
    end
endmodule : pafs_top_bench
